// file: ext_demand_source.sv
// Model of the external controller's demand output
`timescale 1ns/1ps
module ext_demand_source
  import frs_pkg::*;
(
  input wire logic clk,
  input wire logic [1:0] demand_sel,
  input wire logic [frs_pkg::DEMAND_W-1:0] demand_mid,
  output logic [frs_pkg::DEMAND_W-1:0] ext_demand
);
  logic [DEMAND_W-1:0] next_ext_demand;
  always_comb begin
    next_ext_demand = demand_mid;
    if (demand_sel == 2'h0) begin
      next_ext_demand = 12'h000;
    end else if (demand_sel == 2'h1) begin
      next_ext_demand = 12'hFFF;
    end
  end
  always_ff @(posedge clk) begin
    ext_demand <= next_ext_demand;
  end
endmodule : ext_demand_source

// file: firing_rate_source_select.sv
// Firing-rate source selection with cold-start and recirculation holds
// Function
// - Nonzero external mode disables PID; rate follows external demand, low to high fire.
// - Mode 1: thermostat forced closed, no local display, setpoints hidden.
// - Mode 3: load sensor drives thermostat and display; setpoints shown.
// - External modulation without flow metering commissioned stays at low flame hold.
// - Cold start, actual below 30% setpoint: low flame hold for configured minutes.
// - Cold start, actual at or below 60%: hold 50% firing for configured minutes.
// - Actual above proportional band offset ends cold hold; PID resumes.
// - Burner off resets the cold start timer.
// - Cold start setting zero disables; otherwise 1 to 2000 minutes.
// - No cold start while any external modulation mode (1, 2, 3) or terminal external select is in use.
// - Recirculation timer set: hold channels at start positions for that time.
// - Recirculation timer starts when main flame proving completes.
// - Terminal select enabled: PID at 0 V input, external at line voltage.
`timescale 1ns/1ps
module firing_rate_source_select
  import frs_pkg::*;
#(
  parameter longint MINUTE_TICKS = frs_pkg::MINUTE_CYCLES,
  parameter int SECOND_TICKS = frs_pkg::RECIRC_SECOND_CYCLES,
  parameter int RECIRC_W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] ext_mode,
  input wire logic terminal_select_enable,
  input wire logic terminal_select_line,
  input wire logic flow_metering_done,
  input wire logic [frs_pkg::DEMAND_W-1:0] ext_demand,
  input wire logic [frs_pkg::RATE_W-1:0] pid_rate,
  input wire logic [frs_pkg::MIN_W-1:0] cold_start_minutes,
  input wire logic [frs_pkg::VAL_W-1:0] actual_value,
  input wire logic [frs_pkg::VAL_W-1:0] required_setpoint,
  input wire logic [frs_pkg::VAL_W-1:0] pband_offset,
  input wire logic load_sensor_stat_closed,
  input wire logic burner_on,
  input wire logic main_flame_proved,
  input wire logic [RECIRC_W-1:0] recirc_seconds,
  output logic [frs_pkg::RATE_W-1:0] firing_rate,
  output frs_pkg::rate_src_t rate_source,
  output logic pid_enable,
  output logic internal_stat_closed,
  output logic local_display_enable,
  output logic setpoint_display_enable,
  output logic external_stat_required,
  output logic flue_gas_recirculation_hold,
  output logic cold_hold_active
);
  import frs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection
  logic ext_active;
  logic terminal_ext;
  logic [31:0] demand_scaled;
  logic [RATE_W-1:0] ext_rate;
  logic [VAL_W+7:0] actual_pct;
  logic [VAL_W+7:0] low_limit;
  logic [VAL_W+7:0] mid_limit;
  logic below_low;
  logic below_mid;
  logic above_band;

  // Mode 1/2/3 excludes terminal selection, so that option is ignored then
  assign terminal_ext = (ext_mode == EXT_OFF) && terminal_select_enable
                        && terminal_select_line;
  assign ext_active = (ext_mode != EXT_OFF) || terminal_ext;
  // Demand input is normalised by the converter: zero is low fire, full scale high fire
  assign demand_scaled = 32'(ext_demand) * 32'(RATE_HIGH_FIRE - RATE_LOW_FIRE)
                         / 32'((1 << DEMAND_W) - 1);
  assign ext_rate = RATE_W'(demand_scaled) + RATE_LOW_FIRE;

  assign actual_pct = (VAL_W+8)'(actual_value) * (VAL_W+8)'(PCT_FULL);
  assign low_limit = (VAL_W+8)'(required_setpoint) * (VAL_W+8)'(LOW_PCT);
  assign mid_limit = (VAL_W+8)'(required_setpoint) * (VAL_W+8)'(MID_PCT);
  assign below_low = actual_pct < low_limit;
  assign below_mid = actual_pct <= mid_limit;
  assign above_band = actual_value > pband_offset;

  ////////////////////////////////////////////////////////////////////////////
  // Time bases
  logic minute_tick;
  logic second_tick;
  logic cold_clear;
  logic recirc_clear;

  tick_divider #(.PERIOD(MINUTE_TICKS)) u_minute (
    .clk(clk),
    .reset_n(reset_n),
    .clear(cold_clear),
    .tick(minute_tick)
  );

  tick_divider #(.PERIOD(SECOND_TICKS)) u_second (
    .clk(clk),
    .reset_n(reset_n),
    .clear(recirc_clear),
    .tick(second_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Cold start hold
  cold_state_t cold_state;
  cold_state_t next_cold_state;
  logic [MIN_W-1:0] cold_count;
  logic [MIN_W-1:0] next_cold_count;
  logic [MIN_W-1:0] cold_limit;
  logic cold_low;
  logic next_cold_low;
  logic cold_half;
  logic next_cold_half;

  assign cold_limit = (cold_start_minutes > COLD_MINUTES_MAX) ? COLD_MINUTES_MAX
                      : cold_start_minutes;
  assign cold_clear = (cold_state != COLD_ACTIVE);

  always_comb begin
    next_cold_state = cold_state;
    next_cold_count = cold_count;
    next_cold_low = 1'b0;
    next_cold_half = 1'b0;
    case (cold_state)
      COLD_IDLE: begin
        next_cold_count = '0;
        if (burner_on && !ext_active && cold_limit != '0
            && below_mid) begin
          next_cold_state = COLD_ACTIVE;
        end else if (burner_on) begin
          next_cold_state = COLD_DONE;
        end
      end
      COLD_ACTIVE: begin
        if (minute_tick) begin
          next_cold_count = cold_count + MIN_W'(1);
        end
        if (!burner_on) begin
          next_cold_state = COLD_IDLE;
        end else if (ext_active || above_band
                     || next_cold_count >= cold_limit) begin
          next_cold_state = COLD_DONE;
        end else if (below_low) begin
          next_cold_low = 1'b1;
        end else if (below_mid) begin
          next_cold_half = 1'b1;
        end else begin
          next_cold_state = COLD_DONE;
        end
      end
      COLD_DONE: begin
        if (!burner_on) begin
          next_cold_state = COLD_IDLE;
        end
      end
      default: next_cold_state = COLD_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cold_state <= COLD_IDLE;
      cold_count <= '0;
      cold_low <= 1'b0;
      cold_half <= 1'b0;
    end else begin
      cold_state <= next_cold_state;
      cold_count <= next_cold_count;
      cold_low <= next_cold_low;
      cold_half <= next_cold_half;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recirculation hold after main flame proving
  logic [RECIRC_W-1:0] recirc_count;
  logic [RECIRC_W-1:0] next_recirc_count;
  logic recirc_run;
  logic next_recirc_run;
  logic proved_seen;
  logic next_proved_seen;

  assign recirc_clear = !recirc_run;

  always_comb begin
    next_recirc_count = recirc_count;
    next_recirc_run = recirc_run;
    next_proved_seen = proved_seen;
    if (!burner_on) begin
      next_recirc_count = '0;
      next_recirc_run = 1'b0;
      next_proved_seen = 1'b0;
    end else if (main_flame_proved && !proved_seen) begin
      next_proved_seen = 1'b1;
      next_recirc_count = '0;
      next_recirc_run = (recirc_seconds != '0);
    end else if (recirc_run && second_tick) begin
      next_recirc_count = recirc_count + RECIRC_W'(1);
      if (next_recirc_count >= recirc_seconds) begin
        next_recirc_run = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      recirc_count <= '0;
      recirc_run <= 1'b0;
      proved_seen <= 1'b0;
    end else begin
      recirc_count <= next_recirc_count;
      recirc_run <= next_recirc_run;
      proved_seen <= next_proved_seen;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output registers
  logic [RATE_W-1:0] next_firing_rate;
  rate_src_t next_rate_source;
  logic next_pid_enable;
  logic next_internal_stat;
  logic next_local_display;
  logic next_setpoint_display;
  logic next_external_stat;

  always_comb begin
    next_pid_enable = !ext_active;
    next_internal_stat = load_sensor_stat_closed;
    next_local_display = 1'b1;
    next_setpoint_display = 1'b1;
    next_external_stat = 1'b0;
    case (ext_mode)
      EXT_NO_STAT: begin
        next_internal_stat = 1'b1;
        next_local_display = 1'b0;
        next_setpoint_display = 1'b0;
        next_external_stat = 1'b1;
      end
      EXT_SENSOR_DISPLAY: begin
        next_internal_stat = 1'b1;
        next_setpoint_display = 1'b0;
        next_external_stat = 1'b1;
      end
      EXT_SENSOR_STAT: begin
        next_internal_stat = load_sensor_stat_closed;
      end
      default: begin
        if (terminal_ext) begin
          next_setpoint_display = 1'b0;
        end
      end
    endcase
    if (ext_active && !flow_metering_done) begin
      next_rate_source = SRC_LOW_HOLD;
      next_firing_rate = RATE_LOW_FIRE;
    end else if (ext_active) begin
      next_rate_source = SRC_EXTERNAL;
      next_firing_rate = ext_rate;
    end else if (cold_low) begin
      next_rate_source = SRC_LOW_HOLD;
      next_firing_rate = RATE_LOW_FIRE;
    end else if (cold_half) begin
      next_rate_source = SRC_HALF_HOLD;
      next_firing_rate = RATE_HALF_FIRE;
    end else begin
      next_rate_source = SRC_PID;
      next_firing_rate = pid_rate;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      firing_rate <= RATE_LOW_FIRE;
      rate_source <= SRC_PID;
      pid_enable <= 1'b1;
      internal_stat_closed <= 1'b0;
      local_display_enable <= 1'b1;
      setpoint_display_enable <= 1'b1;
      external_stat_required <= 1'b0;
      flue_gas_recirculation_hold <= 1'b0;
      cold_hold_active <= 1'b0;
    end else begin
      firing_rate <= next_firing_rate;
      rate_source <= next_rate_source;
      pid_enable <= next_pid_enable;
      internal_stat_closed <= next_internal_stat;
      local_display_enable <= next_local_display;
      setpoint_display_enable <= next_setpoint_display;
      external_stat_required <= next_external_stat;
      flue_gas_recirculation_hold <= next_recirc_run;
      cold_hold_active <= next_cold_low | next_cold_half;
    end
  end
endmodule : firing_rate_source_select

// file: frs_pkg.sv
// Constants and types for the firing-rate source selection block
package frs_pkg;
  localparam int RATE_W = 10;
  localparam int VAL_W = 16;
  localparam int MIN_W = 11;
  localparam int DEMAND_W = 12;
  localparam int CLK_HZ = 125000000;
  localparam int SECONDS_PER_MINUTE = 60;
  // A minute of clock cycles does not fit in 32 bits
  localparam longint MINUTE_CYCLES = longint'(CLK_HZ) * SECONDS_PER_MINUTE;
  localparam int RECIRC_SECOND_CYCLES = CLK_HZ;
  localparam logic [RATE_W-1:0] RATE_LOW_FIRE = 10'h000;
  localparam logic [RATE_W-1:0] RATE_HIGH_FIRE = 10'h3E8;
  localparam logic [RATE_W-1:0] RATE_HALF_FIRE = 10'h1F4;
  localparam logic [1:0] EXT_OFF = 2'h0;
  localparam logic [1:0] EXT_NO_STAT = 2'h1;
  localparam logic [1:0] EXT_SENSOR_DISPLAY = 2'h2;
  localparam logic [1:0] EXT_SENSOR_STAT = 2'h3;
  localparam logic [10:0] COLD_MINUTES_MAX = 11'h7D0;
  localparam int LOW_PCT = 30;
  localparam int MID_PCT = 60;
  localparam int PCT_FULL = 100;
  typedef enum logic [1:0] {
    SRC_PID, SRC_EXTERNAL, SRC_LOW_HOLD, SRC_HALF_HOLD
  } rate_src_t;
  typedef enum {
    COLD_IDLE, COLD_ACTIVE, COLD_DONE
  } cold_state_t;
endpackage : frs_pkg

// file: frs_props.sv
// Port checker for the firing-rate source selection block
`timescale 1ns/1ps
module frs_props
  import frs_pkg::*;
#(
  parameter longint MINUTE_TICKS = 20,
  parameter int SECOND_TICKS = 10,
  parameter int RECIRC_W = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] ext_mode,
  input wire logic terminal_select_enable,
  input wire logic terminal_select_line,
  input wire logic flow_metering_done,
  input wire logic load_sensor_stat_closed,
  input wire logic burner_on,
  input wire logic main_flame_proved,
  input wire logic [RECIRC_W-1:0] recirc_seconds,
  input wire logic [frs_pkg::RATE_W-1:0] firing_rate,
  input wire frs_pkg::rate_src_t rate_source,
  input wire logic pid_enable,
  input wire logic internal_stat_closed,
  input wire logic local_display_enable,
  input wire logic setpoint_display_enable,
  input wire logic external_stat_required,
  input wire logic flue_gas_recirculation_hold,
  input wire logic cold_hold_active
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_ext_no_pid: assert property (ext_mode != EXT_OFF |=> !pid_enable)
    else $error("pid left on in external mode");
  a_mode_one: assert property (ext_mode == EXT_NO_STAT |=> internal_stat_closed
    && !local_display_enable && !setpoint_display_enable && external_stat_required)
    else $error("mode one outputs wrong");
  a_mode_two: assert property (ext_mode == EXT_SENSOR_DISPLAY |=> internal_stat_closed
    && local_display_enable && !setpoint_display_enable && external_stat_required)
    else $error("mode two outputs wrong");
  a_mode_three: assert property (ext_mode == EXT_SENSOR_STAT |=>
    internal_stat_closed == $past(load_sensor_stat_closed) && local_display_enable
    && setpoint_display_enable && !external_stat_required)
    else $error("mode three outputs wrong");
  a_no_metering_hold: assert property (ext_mode != EXT_OFF && !flow_metering_done |=>
    rate_source == SRC_LOW_HOLD && firing_rate == RATE_LOW_FIRE)
    else $error("no low flame hold without metering");
  a_terminal_ext: assert property (ext_mode == EXT_OFF && terminal_select_enable
    && terminal_select_line |=> !pid_enable)
    else $error("terminal select ignored");
  a_burner_off_clear: assert property (!burner_on [*2] |=> !cold_hold_active)
    else $error("cold hold kept with burner off");
  a_recirc_start: assert property (burner_on && $rose(main_flame_proved)
    && recirc_seconds != 0 |=> flue_gas_recirculation_hold)
    else $error("recirculation hold not started");
endmodule : frs_props

bind firing_rate_source_select frs_props #(.MINUTE_TICKS(MINUTE_TICKS),
  .SECOND_TICKS(SECOND_TICKS), .RECIRC_W(RECIRC_W)) props_u (.*);

// file: testbench.sv
// Self-checking testbench for firing-rate source selection
`timescale 1ns/1ps
module testbench;
  import frs_pkg::*;
  logic clk, reset_n, terminal_select_enable, terminal_select_line, flow_metering_done;
  logic load_sensor_stat_closed, burner_on, main_flame_proved, chk_on;
  logic [1:0] ext_mode, demand_sel, r_mode;
  logic [DEMAND_W-1:0] ext_demand, demand_mid;
  logic [RATE_W-1:0] pid_rate, firing_rate;
  logic [MIN_W-1:0] cold_start_minutes;
  logic [VAL_W-1:0] actual_value, required_setpoint, pband_offset;
  logic [15:0] recirc_seconds;
  rate_src_t rate_source;
  logic pid_enable, internal_stat_closed, local_display_enable, setpoint_display_enable;
  logic external_stat_required, flue_gas_recirculation_hold, cold_hold_active;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  integer seed = 32'h4687d63c;
  logic [1:0] p_mode;
  logic p_tse, p_tsl, p_flow, p_load;
  logic [DEMAND_W-1:0] p_dem;
  logic [RATE_W-1:0] p_pid;
  firing_rate_source_select #(.MINUTE_TICKS(20), .SECOND_TICKS(10)) dut_u (.*);
  ext_demand_source model_u (.*);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  //////////////////////////////////////////////////////////////////////////////
  // Reference model: outputs one cycle after the inputs they answer
  always @(posedge clk) begin
    logic ext;
    int e;
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      complete_run();
    end
    ext = p_mode != 2'h0 || (p_tse && p_tsl);
    e = !ext ? int'(p_pid) : !p_flow ? 0 : int'(p_dem) * int'(RATE_HIGH_FIRE) / 4095;
    if (chk_on) begin
      check_val(16'(pid_enable), 16'(!ext));
      check_val(16'(rate_source), 16'(!ext ? SRC_PID : p_flow ? SRC_EXTERNAL : SRC_LOW_HOLD));
      if (e >= 0) check_val(16'(firing_rate), 16'(e));
      if (p_mode != 2'h0) begin
        check_val(16'(internal_stat_closed), 16'(p_mode == 2'h3 ? p_load : 1'b1));
        check_val(16'({local_display_enable, setpoint_display_enable, external_stat_required}),
          16'({p_mode != 2'h1, p_mode == 2'h3, p_mode != 2'h3}));
      end else begin
        check_val(16'(internal_stat_closed), 16'(p_load));
        check_val(16'({local_display_enable, setpoint_display_enable, external_stat_required}),
          16'({1'b1, !(p_tse && p_tsl), 1'b0}));
      end
    end
    p_mode = ext_mode;
    p_tse = terminal_select_enable;
    p_tsl = terminal_select_line;
    p_flow = flow_metering_done;
    p_load = load_sensor_stat_closed;
    p_dem = ext_demand;
    p_pid = pid_rate;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Burner start with a given load; checks the cold hold outputs six cycles on
  task automatic cold_run(input int act, input int mins, input int md, input int src,
    input int rate, input logic hold);
    burner_on <= 1'b0;
    ext_mode <= 2'(md);
    actual_value <= 16'(act);
    cold_start_minutes <= 11'(mins);
    repeat (3) @(posedge clk);
    burner_on <= 1'b1;
    repeat (6) @(posedge clk);
    check_val(16'(cold_hold_active), 16'(hold));
    check_val(16'(rate_source), 16'(src));
    check_val(16'(firing_rate), 16'(rate));
  endtask : cold_run
  initial begin
    {reset_n, chk_on, terminal_select_enable, terminal_select_line, burner_on} = 5'h00;
    {main_flame_proved, load_sensor_stat_closed, ext_mode, demand_sel} = 6'h00;
    flow_metering_done = 1'b1;
    demand_mid = 12'h800;
    pid_rate = 10'h123;
    cold_start_minutes = 11'h000;
    {actual_value, required_setpoint, pband_offset} = {16'h0014, 16'h0064, 16'h005A};
    recirc_seconds = 16'h0000;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    repeat (300) begin
      @(posedge clk);
      chk_on <= 1'b1;
      r_mode = 2'($random(seed));
      ext_mode <= r_mode;
      // Terminal option stays off whenever an external mode is set
      {terminal_select_enable, terminal_select_line} <=
        2'($random(seed)) & {r_mode == 2'h0, 1'b1};
      {flow_metering_done, load_sensor_stat_closed} <= 2'($random(seed));
      demand_sel <= 2'($random(seed));
      demand_mid <= 12'($random(seed));
      pid_rate <= 10'($random(seed));
    end
    @(posedge clk);
    chk_on <= 1'b0;
    {terminal_select_enable, flow_metering_done, demand_sel, pid_rate} <= {4'h5, 10'h123};
    cold_run(20, 2, 0, SRC_LOW_HOLD, 0, 1);
    cold_run(30, 2, 0, SRC_HALF_HOLD, 500, 1);
    cold_run(60, 2, 0, SRC_HALF_HOLD, 500, 1);
    cold_run(61, 2, 0, SRC_PID, 'h123, 0);
    cold_run(20, 0, 0, SRC_PID, 'h123, 0);
    cold_run(20, 2, 1, SRC_EXTERNAL, 1000, 0);
    cold_run(20, 3, 0, SRC_LOW_HOLD, 0, 1);
    repeat (30) @(posedge clk);
    check_val(16'(cold_hold_active), 16'h0001);
    repeat (50) @(posedge clk);
    check_val(16'(rate_source), 16'(SRC_PID));
    cold_run(20, 3, 0, SRC_LOW_HOLD, 0, 1);
    {actual_value, pband_offset} <= {16'h0032, 16'h0028};
    repeat (5) @(posedge clk);
    check_val(16'(cold_hold_active), 16'h0000);
    actual_value <= 16'h0014;
    repeat (5) @(posedge clk);
    check_val(16'(rate_source), 16'(SRC_PID));
    cold_start_minutes <= 11'h000;
    recirc_seconds <= 16'h0003;
    @(posedge clk);
    main_flame_proved <= 1'b1;
    repeat (3) @(posedge clk);
    check_val(16'(flue_gas_recirculation_hold), 16'h0001);
    repeat (20) @(posedge clk);
    check_val(16'(flue_gas_recirculation_hold), 16'h0001);
    repeat (20) @(posedge clk);
    check_val(16'(flue_gas_recirculation_hold), 16'h0000);
    complete_run();
  end
endmodule : testbench

// file: tick_divider.sv
// Divider that produces a one-cycle enable pulse every period cycles
`timescale 1ns/1ps
module tick_divider #(
  parameter longint PERIOD = 125000000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  output logic tick
);
  localparam int CNT_W = $clog2(PERIOD + 1);
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic next_tick;

  always_comb begin
    next_count = count + CNT_W'(1);
    next_tick = 1'b0;
    if (clear) begin
      next_count = '0;
    end else if (count >= CNT_W'(PERIOD - 1)) begin
      next_count = '0;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule : tick_divider
